// *** logic/sfr_cfg.svh ***
// Purpose: Constants of the core special register bank.
// Assumes: Register indices are word indices on the bus.
// Notes: Included by the register bank, the bank monitor and the bench.
`ifndef SFR_CFG_SVH
`define SFR_CFG_SVH
// ----------------------------------------
// Register indices
// ----------------------------------------
`define A_P0 8'h80
`define A_SP 8'h81
`define A_DPL 8'h82
`define A_DPH 8'h83
`define A_POWER_CONTROL 8'h87
`define A_TIMER_CONTROL 8'h88
`define A_TIMER_MODE_SELECT 8'h89
`define A_TL0 8'h8a
`define A_TL1 8'h8b
`define A_TH0 8'h8c
`define A_TH1 8'h8d
`define A_AUXILIARY_CONFIG 8'h8e
`define A_CLOCK_CONFIG 8'h8f
`define A_P1 8'h90
`define A_SERIAL_CONTROL 8'h98
`define A_SERIAL_DATA_BUFFER 8'h99
`define A_P2 8'ha0
`define A_IE 8'ha8
`define A_P3 8'hb0
`define A_IP 8'hb8
`define A_TIMER2_CONTROL 8'hc8
`define A_RCAPL 8'hca
`define A_RCAPH 8'hcb
`define A_TL2 8'hcc
`define A_TH2 8'hcd
`define A_PSW 8'hd0
`define A_ACC 8'he0
`define A_B 8'hf0
// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define SP_RESET 8'h07
`define BYTE_ZERO 8'h00
`define WORD_ZERO 16'h0000
`define WORD_ONE 16'h0001
`define WORD_FULL 16'hffff
`define BUS_ZERO 32'h0000_0000
`define PSW_CY 7
`define PSW_AC 6
`define PSW_F0 5
`define PSW_RS_HI 4
`define PSW_RS_LO 3
`define PSW_OV 2
`define PSW_RSV 1
`define PSW_PAR 0
`define T2_CAPTURE_BIT 0
`define T2_TRIG_EN_BIT 3
`define TIMER2_PRESENT 1'b1
`define TIMER_COUNT 3
`endif

// *** logic/sfr_pkg.sv ***
// Purpose: Types of the core special register bank.
// Assumes: Eight-bit special registers.
// Notes: Numbers live in sfr_cfg.svh.
`default_nettype none
package sfr_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] word_t;
endpackage : sfr_pkg
`default_nettype wire

// *** logic/core_special_register_bank.sv ***
// Purpose: Special function register bank of an 8-bit core.
// Assumes: Classic Wishbone slave, 32-bit data, byte data in bits 7:0.
// Notes: Core-side hardware strobes are one-cycle pulses.
//
// Decided for this implementation: the Wishbone interface to the registers.
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module core_special_register_bank
    import sfr_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Core stack and flags
    input wire logic stack_push_i,
    input wire logic stack_pop_i,
    input wire logic flags_we_i,
    input wire logic carry_flag_i,
    input wire logic half_carry_flag_i,
    input wire logic twos_complement_range_flag_i,
    input wire logic mul_div_we_i,
    input wire logic [7:0] mul_div_acc_i,
    input wire logic [7:0] mul_div_aux_i,
    input wire logic pointer_inc_i,
    input wire logic pointer_load_i,
    input wire logic [15:0] pointer_value_i,
    // Timers and serial
    input wire logic [2:0] timer_inc_i,
    input wire logic timer2_trigger_input_i,
    input wire logic rx_load_i,
    input wire logic [7:0] rx_data_i,
    // State to the core
    output logic [7:0] program_status_o,
    output logic [4:0] bank_base_o,
    output logic [7:0] stack_pointer_o,
    output logic [7:0] main_operand_o,
    output logic [7:0] multiply_divide_aux_o,
    output logic [15:0] indirect_address_pointer_o,
    // State to peripherals
    output logic [7:0] tx_data_o,
    output logic tx_start_o,
    output logic [31:0] port_latch_o,
    output logic [47:0] timer_count_o,
    output logic [7:0] timer_control_o,
    output logic [7:0] timer_mode_select_o,
    output logic [7:0] serial_control_o,
    output logic [7:0] interrupt_enable_o,
    output logic [7:0] interrupt_priority_o,
    output logic [7:0] power_control_o
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    logic ack_reg;
    logic req;
    logic wr;
    logic [7:0] idx;
    byte_t wdat;
    byte_t rdat;
    assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
    assign wr = req & wb_we_i & wb_sel_i[0];
    assign idx = wb_adr_i[9:2];
    assign wdat = wb_dat_i[7:0];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction : hit

    function automatic logic [7:0] lo_addr(input int t);
        case (t)
            0: lo_addr = `A_TL0;
            1: lo_addr = `A_TL1;
            default: lo_addr = `A_TL2;
        endcase
    endfunction : lo_addr

    function automatic logic [7:0] hi_addr(input int t);
        case (t)
            0: hi_addr = `A_TH0;
            1: hi_addr = `A_TH1;
            default: hi_addr = `A_TH2;
        endcase
    endfunction : hi_addr

    // ----------------------------------------
    // Plain control and port latches
    // ----------------------------------------
    byte_t port_reg [4];
    byte_t power_control_reg, timer_control_reg, timer_mode_select_reg, auxiliary_config_reg, clock_config_reg;
    byte_t serial_control_reg, ie_reg, ip_reg, timer2_control_reg;
    logic t2_ok;
    assign t2_ok = `TIMER2_PRESENT;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int p = 0; p < 4; p++) begin
                port_reg[p] <= `BYTE_ZERO;
            end
        end else if (wr) begin
            if (hit(idx, `A_P0)) port_reg[0] <= wdat;
            if (hit(idx, `A_P1)) port_reg[1] <= wdat;
            if (hit(idx, `A_P2)) port_reg[2] <= wdat;
            if (hit(idx, `A_P3)) port_reg[3] <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_control_reg <= `BYTE_ZERO;
            timer_control_reg <= `BYTE_ZERO;
            timer_mode_select_reg <= `BYTE_ZERO;
            auxiliary_config_reg <= `BYTE_ZERO;
            clock_config_reg <= `BYTE_ZERO;
            serial_control_reg <= `BYTE_ZERO;
            ie_reg <= `BYTE_ZERO;
            ip_reg <= `BYTE_ZERO;
            timer2_control_reg <= `BYTE_ZERO;
        end else if (wr) begin
            if (hit(idx, `A_POWER_CONTROL)) power_control_reg <= wdat;
            if (hit(idx, `A_TIMER_CONTROL)) timer_control_reg <= wdat;
            if (hit(idx, `A_TIMER_MODE_SELECT)) timer_mode_select_reg <= wdat;
            if (hit(idx, `A_AUXILIARY_CONFIG)) auxiliary_config_reg <= wdat;
            if (hit(idx, `A_CLOCK_CONFIG)) clock_config_reg <= wdat;
            if (hit(idx, `A_SERIAL_CONTROL)) serial_control_reg <= wdat;
            if (hit(idx, `A_IE)) ie_reg <= wdat;
            if (hit(idx, `A_IP)) ip_reg <= wdat;
            if (hit(idx, `A_TIMER2_CONTROL) && t2_ok) timer2_control_reg <= wdat;
        end
    end

    // ----------------------------------------
    // Accumulator, auxiliary byte, status word
    // ----------------------------------------
    byte_t acc_reg, b_reg, psw_reg, psw_next;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= `BYTE_ZERO;
            b_reg <= `BYTE_ZERO;
        end else begin
            // A bus write wins over a result landing in the same cycle.
            if (wr && hit(idx, `A_ACC)) acc_reg <= wdat;
            else if (mul_div_we_i) acc_reg <= mul_div_acc_i;
            if (wr && hit(idx, `A_B)) b_reg <= wdat;
            else if (mul_div_we_i) b_reg <= mul_div_aux_i;
        end
    end

    always_comb begin
        psw_next = psw_reg;
        if (flags_we_i) begin
            psw_next[`PSW_CY] = carry_flag_i;
            psw_next[`PSW_AC] = half_carry_flag_i;
            psw_next[`PSW_OV] = twos_complement_range_flag_i;
        end
        if (wr && hit(idx, `A_PSW)) begin
            psw_next = wdat;
        end
        psw_next[`PSW_RSV] = 1'b0;
        // Parity follows the accumulator one clock behind its update.
        psw_next[`PSW_PAR] = ^acc_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psw_reg <= `BYTE_ZERO;
            bank_base_o <= 5'h00;
        end else begin
            psw_reg <= psw_next;
            bank_base_o <= {psw_next[`PSW_RS_HI:`PSW_RS_LO], 3'h0};
        end
    end

    // ----------------------------------------
    // Stack and data pointers
    // ----------------------------------------
    byte_t sp_reg;
    word_t indirect_address_pointer_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sp_reg <= `SP_RESET;
        end else if (wr && hit(idx, `A_SP)) begin
            sp_reg <= wdat;
        end else if (stack_push_i) begin
            // The core stores at the new value, so the first push lands one above.
            sp_reg <= sp_reg + 8'h01;
        end else if (stack_pop_i) begin
            sp_reg <= sp_reg - 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            indirect_address_pointer_reg <= `WORD_ZERO;
        end else if (wr && hit(idx, `A_DPL)) begin
            indirect_address_pointer_reg[7:0] <= wdat;
        end else if (wr && hit(idx, `A_DPH)) begin
            indirect_address_pointer_reg[15:8] <= wdat;
        end else if (pointer_load_i) begin
            indirect_address_pointer_reg <= pointer_value_i;
        end else if (pointer_inc_i) begin
            indirect_address_pointer_reg <= indirect_address_pointer_reg + `WORD_ONE;
        end
    end

    // ----------------------------------------
    // Serial buffer split
    // ----------------------------------------
    byte_t tx_reg, rx_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_reg <= `BYTE_ZERO;
            tx_start_o <= 1'b0;
        end else begin
            tx_start_o <= wr && hit(idx, `A_SERIAL_DATA_BUFFER);
            if (wr && hit(idx, `A_SERIAL_DATA_BUFFER)) tx_reg <= wdat;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_reg <= `BYTE_ZERO;
        end else if (rx_load_i) begin
            rx_reg <= rx_data_i;
        end
    end

    // ----------------------------------------
    // Timer count pairs and timer-2 capture
    // ----------------------------------------
    word_t cnt_reg [`TIMER_COUNT];
    word_t cap_reg;
    logic trig_prev_reg;
    logic trig_fall;
    logic t2_capture;
    logic t2_ovf;
    assign trig_fall = trig_prev_reg & ~timer2_trigger_input_i;
    assign t2_capture = t2_ok & timer2_control_reg[`T2_CAPTURE_BIT];
    assign t2_ovf = timer_inc_i[2] && (cnt_reg[2] == `WORD_FULL);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_prev_reg <= 1'b0;
        end else begin
            trig_prev_reg <= timer2_trigger_input_i;
        end
    end

    genvar t;
    generate
        for (t = 0; t < `TIMER_COUNT; t++) begin : g_timer
            logic sw_lo, sw_hi, reload;
            assign sw_lo = wr && hit(idx, lo_addr(t)) && (t < 2 || t2_ok);
            assign sw_hi = wr && hit(idx, hi_addr(t)) && (t < 2 || t2_ok);
            if (t == 2) begin : g_reload
                // Outside capture mode, reload on overflow, or on trigger when it is enabled.
                assign reload = ~t2_capture && (t2_ovf ||
                    (trig_fall && timer2_control_reg[`T2_TRIG_EN_BIT]));
            end else begin : g_noreload
                assign reload = 1'b0;
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    cnt_reg[t] <= `WORD_ZERO;
                end else if (sw_lo) begin
                    cnt_reg[t][7:0] <= wdat;
                end else if (sw_hi) begin
                    cnt_reg[t][15:8] <= wdat;
                end else if (reload) begin
                    cnt_reg[t] <= cap_reg;
                end else if (timer_inc_i[t]) begin
                    cnt_reg[t] <= cnt_reg[t] + `WORD_ONE;
                end
            end
            assign timer_count_o[t*16 +: 16] = cnt_reg[t];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cap_reg <= `WORD_ZERO;
        end else if (wr && t2_ok && hit(idx, `A_RCAPL)) begin
            cap_reg[7:0] <= wdat;
        end else if (wr && t2_ok && hit(idx, `A_RCAPH)) begin
            cap_reg[15:8] <= wdat;
        end else if (t2_capture && trig_fall && timer2_control_reg[`T2_TRIG_EN_BIT]) begin
            cap_reg <= cnt_reg[2];
        end
    end

    // ----------------------------------------
    // Read mux and acknowledge
    // ----------------------------------------
    always_comb begin
        // Unoccupied indices read zero, a defined choice among any value.
        rdat = `BYTE_ZERO;
        unique case (idx)
            `A_P0: rdat = port_reg[0];
            `A_P1: rdat = port_reg[1];
            `A_P2: rdat = port_reg[2];
            `A_P3: rdat = port_reg[3];
            `A_SP: rdat = sp_reg;
            `A_DPL: rdat = indirect_address_pointer_reg[7:0];
            `A_DPH: rdat = indirect_address_pointer_reg[15:8];
            `A_POWER_CONTROL: rdat = power_control_reg;
            `A_TIMER_CONTROL: rdat = timer_control_reg;
            `A_TIMER_MODE_SELECT: rdat = timer_mode_select_reg;
            `A_TL0: rdat = cnt_reg[0][7:0];
            `A_TL1: rdat = cnt_reg[1][7:0];
            `A_TH0: rdat = cnt_reg[0][15:8];
            `A_TH1: rdat = cnt_reg[1][15:8];
            `A_AUXILIARY_CONFIG: rdat = auxiliary_config_reg;
            `A_CLOCK_CONFIG: rdat = clock_config_reg;
            `A_SERIAL_CONTROL: rdat = serial_control_reg;
            `A_SERIAL_DATA_BUFFER: rdat = rx_reg;
            `A_IE: rdat = ie_reg;
            `A_IP: rdat = ip_reg;
            `A_TIMER2_CONTROL: rdat = timer2_control_reg;
            `A_RCAPL: rdat = t2_ok ? cap_reg[7:0] : `BYTE_ZERO;
            `A_RCAPH: rdat = t2_ok ? cap_reg[15:8] : `BYTE_ZERO;
            `A_TL2: rdat = t2_ok ? cnt_reg[2][7:0] : `BYTE_ZERO;
            `A_TH2: rdat = t2_ok ? cnt_reg[2][15:8] : `BYTE_ZERO;
            `A_PSW: rdat = psw_reg;
            `A_ACC: rdat = acc_reg;
            `A_B: rdat = b_reg;
            default: rdat = `BYTE_ZERO;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            wb_dat_o <= `BUS_ZERO;
        end else begin
            ack_reg <= req;
            if (req) wb_dat_o <= {24'h00_0000, rdat};
        end
    end

    // ----------------------------------------
    // Registered outputs
    // ----------------------------------------
    assign wb_ack_o = ack_reg;
    assign program_status_o = psw_reg;
    assign stack_pointer_o = sp_reg;
    assign main_operand_o = acc_reg;
    assign multiply_divide_aux_o = b_reg;
    assign indirect_address_pointer_o = indirect_address_pointer_reg;
    assign tx_data_o = tx_reg;
    assign port_latch_o = {port_reg[3], port_reg[2], port_reg[1], port_reg[0]};
    assign timer_control_o = timer_control_reg;
    assign timer_mode_select_o = timer_mode_select_reg;
    assign serial_control_o = serial_control_reg;
    assign interrupt_enable_o = ie_reg;
    assign interrupt_priority_o = ip_reg;
    assign power_control_o = power_control_reg;
endmodule : core_special_register_bank
`default_nettype wire

// *** sim/sfr_bank_monitor.sv ***
// Purpose: Checker of the special register bank at its top ports.
// Assumes: One clock domain, reset synchronous and active high.
// Notes: Bound to the bank from the bench top file.
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sfr_bank_monitor (
    // Bus side
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Core side
    input wire logic stack_push_i,
    input wire logic pointer_inc_i,
    input wire logic pointer_load_i,
    input wire logic [2:0] timer_inc_i,
    input wire logic [7:0] program_status_o,
    input wire logic [4:0] bank_base_o,
    input wire logic [7:0] stack_pointer_o,
    input wire logic [7:0] main_operand_o,
    input wire logic [15:0] indirect_address_pointer_o,
    input wire logic tx_start_o,
    input wire logic [47:0] timer_count_o
);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // A bus write wins over core strobes, so strobe checks skip that edge.
    logic wr;
    logic [7:0] idx;
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o;
    assign idx = wb_adr_i[9:2];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_single_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack is not one pulse one cycle after request");
    a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0000_00)
        else $error("read data upper bits not zero");
    a_sp_reset_value: assert property ($fell(rst_i) |-> stack_pointer_o == `SP_RESET)
        else $error("stack pointer reset value wrong");
    a_sp_push_step: assert property (stack_push_i && !(wr && idx == `A_SP)
        |=> stack_pointer_o == $past(stack_pointer_o) + 8'h01)
        else $error("push did not add one to stack pointer");
    a_parity_tracks: assert property (program_status_o[0] == ^$past(main_operand_o))
        else $error("parity bit does not follow accumulator");
    a_bank_base_map: assert property (bank_base_o == {program_status_o[4:3], 3'b000})
        else $error("bank base does not match select bits");
    a_tx_start_write: assert property (wr && idx == `A_SERIAL_DATA_BUFFER |=> tx_start_o && wb_ack_o)
        else $error("serial buffer write did not start sending");
    a_pointer_step: assert property (pointer_inc_i && !pointer_load_i && !(wr && (idx == `A_DPL || idx == `A_DPH))
        |=> indirect_address_pointer_o == $past(indirect_address_pointer_o) + 16'h0001)
        else $error("data pointer did not step by one");
    a_timer0_step: assert property (timer_inc_i[0] && !(wr && (idx == `A_TL0 || idx == `A_TH0))
        |=> timer_count_o[15:0] == $past(timer_count_o[15:0]) + 16'h0001)
        else $error("timer zero count did not step by one");
endmodule : sfr_bank_monitor
`default_nettype wire

// *** sim/core_model.sv ***
// Purpose: Behavioural stand-in for the execution core.
// Assumes: One command per go pulse, set just after a rising edge.
// Notes: Each strobe lasts exactly the cycle that go is high.
`timescale 1ns/1ps
`default_nettype none
module core_model (
    // Commands from the bench
    input wire logic go_i,
    input wire logic [2:0] op_i,
    input wire logic [15:0] val_i,
    // Strobes to the bank
    output logic push_o,
    output logic pop_o,
    output logic flags_o,
    output logic muldiv_o,
    output logic ptr_inc_o,
    output logic ptr_load_o,
    output logic [2:0] tinc_o,
    output logic rx_load_o
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    // Payloads come straight from val_i, so only strobes are decoded here.
    assign push_o = go_i && op_i == 3'h0;
    assign pop_o = go_i && op_i == 3'h1;
    assign flags_o = go_i && op_i == 3'h2;
    assign muldiv_o = go_i && op_i == 3'h3;
    assign ptr_inc_o = go_i && op_i == 3'h4;
    assign ptr_load_o = go_i && op_i == 3'h5;
    assign tinc_o = (go_i && op_i == 3'h6) ? val_i[2:0] : 3'h0;
    assign rx_load_o = go_i && op_i == 3'h7;
endmodule : core_model
`default_nettype wire

// *** sim/tb_top.sv ***
// Purpose: Self-checking bench of the special register bank.
// Assumes: Wishbone classic master, one idle cycle between requests.
// Notes: A byte mirror of every index holds the expected contents.
`include "sfr_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, trig = 1;
    logic [9:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] dat = 0, dw, dout;
    logic [2:0] op = 0, tinc;
    logic [15:0] val = 0, indirect_address_pointer;
    logic ack, push, pop, flg, mdw, pinc, pld, rxl;
    logic [7:0] program_status, sp, txd, v, w8;
    logic [4:0] bank;
    logic [31:0] ports;
    logic [47:0] tcnt, ctl;
    logic [7:0] acco, aux;
    logic txs, tsp;
    logic [7:0] mir [256];
    logic [7:0] rw [24] = '{8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
        8'h8e, 8'h8f, 8'h90, 8'h98, 8'ha0, 8'ha8, 8'hb0, 8'hb8, 8'hca, 8'hcb, 8'hcc, 8'he0, 8'hf0};
    int failures = 0, cmp_count = 0;
    int unsigned seed = 12;
    always #2.5 clk_i = ~clk_i;
    core_model core_model_i (.go_i(go), .op_i(op), .val_i(val), .push_o(push), .pop_o(pop), .flags_o(flg),
        .muldiv_o(mdw), .ptr_inc_o(pinc), .ptr_load_o(pld), .tinc_o(tinc), .rx_load_o(rxl));
    core_special_register_bank core_special_register_bank_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dw),
        .wb_ack_o(ack), .stack_push_i(push), .stack_pop_i(pop), .flags_we_i(flg), .carry_flag_i(val[7]),
        .half_carry_flag_i(val[6]), .twos_complement_range_flag_i(val[2]), .mul_div_we_i(mdw),
        .mul_div_acc_i(val[7:0]), .mul_div_aux_i(val[15:8]), .pointer_inc_i(pinc), .pointer_load_i(pld),
        .pointer_value_i(val), .timer_inc_i(tinc), .timer2_trigger_input_i(trig), .rx_load_i(rxl),
        .rx_data_i(val[7:0]), .program_status_o(program_status), .bank_base_o(bank), .stack_pointer_o(sp),
        .main_operand_o(acco), .multiply_divide_aux_o(aux), .indirect_address_pointer_o(indirect_address_pointer), .tx_data_o(txd),
        .tx_start_o(txs), .port_latch_o(ports), .timer_count_o(tcnt), .timer_control_o(ctl[7:0]),
        .timer_mode_select_o(ctl[15:8]), .serial_control_o(ctl[23:16]), .interrupt_enable_o(ctl[31:24]),
        .interrupt_priority_o(ctl[39:32]), .power_control_o(ctl[47:40]));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction : rnd
    function automatic logic [15:0] cnt(input logic [7:0] h, input logic [7:0] l);
        return {mir[h], mir[l]} + 16'h0001;
    endfunction : cnt
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Upper write bits are random so a decoder that looks past bit 7 shows up.
    task automatic bus(input logic w, input logic [7:0] i, input logic [7:0] d);
        int n;
        n = 0;
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'hf;
        dat <= {rnd(), rnd(), rnd(), d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        dout = dw;
        tsp = txs;
        if (w) mir[i] = d;
        cyc <= 0;
        stb <= 0;
        @(posedge clk_i);
    endtask : bus
    task automatic rdc(input logic [7:0] i, input logic [7:0] e);
        bus(0, i, 8'h00);
        chk({16'h0000, dout}, {40'h00_0000_0000, e});
    endtask : rdc
    task automatic core(input logic [2:0] o, input logic [15:0] d);
        go <= 1;
        op <= o;
        val <= d;
        @(posedge clk_i);
        go <= 0;
        @(posedge clk_i);
    endtask : core
    task automatic fall();
        trig <= 0;
        repeat (3) @(posedge clk_i);
        trig <= 1;
        repeat (2) @(posedge clk_i);
    endtask : fall
    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        end_sim();
    end
    initial begin
        foreach (mir[k]) mir[k] = 8'h00;
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        rdc(`A_SP, 8'h07);
        chk(sp, 8'h07);
        rdc(`A_P0, 8'h00);
        rdc(8'h85, 8'h00);
        foreach (rw[k]) bus(1, rw[k], rnd());
        foreach (rw[k]) rdc(rw[k], mir[rw[k]]);
        chk(ports, {mir[`A_P3], mir[`A_P2], mir[`A_P1], mir[`A_P0]});
        chk(indirect_address_pointer, {mir[`A_DPH], mir[`A_DPL]});
        chk(ctl, {mir[`A_POWER_CONTROL], mir[`A_IP], mir[`A_IE], mir[`A_SERIAL_CONTROL], mir[`A_TIMER_MODE_SELECT], mir[`A_TIMER_CONTROL]});
        for (int b = 0; b < 4; b++) begin
            v = rnd();
            v[4:3] = b[1:0];
            bus(1, `A_PSW, v);
            mir[`A_PSW] = {v[7:2], 1'b0, ^mir[`A_ACC]};
            rdc(`A_PSW, mir[`A_PSW]);
            chk(bank, {b[1:0], 3'b000});
        end
        core(3'h2, 16'h0085);
        rdc(`A_PSW, {2'b10, mir[`A_PSW][5:3], 2'b10, mir[`A_PSW][0]});
        v = rnd();
        w8 = rnd();
        core(3'h3, {w8, v});
        rdc(`A_ACC, v);
        rdc(`A_B, w8);
        chk(aux, w8);
        chk(acco, v);
        chk(program_status[0], ^v);
        core(3'h0, 16'h0000);
        core(3'h0, 16'h0000);
        core(3'h1, 16'h0000);
        rdc(`A_SP, mir[`A_SP] + 8'h01);
        bus(1, `A_SP, 8'hff);
        core(3'h0, 16'h0000);
        rdc(`A_SP, 8'h00);
        core(3'h5, 16'h00ff);
        core(3'h4, 16'h0000);
        rdc(`A_DPL, 8'h00);
        rdc(`A_DPH, 8'h01);
        core(3'h7, {8'h00, v});
        bus(1, `A_SERIAL_DATA_BUFFER, w8);
        chk(txd, w8);
        chk(tsp, 1'b1);
        rdc(`A_SERIAL_DATA_BUFFER, v);
        chk(tsp, 1'b0);
        bus(1, `A_TL2, rnd());
        bus(1, `A_TH2, 8'h00);
        core(3'h6, 16'h0007);
        chk(tcnt, {cnt(`A_TH2, `A_TL2), cnt(`A_TH1, `A_TL1), cnt(`A_TH0, `A_TL0)});
        bus(1, `A_TIMER2_CONTROL, 8'h09);
        bus(1, `A_TL2, 8'h34);
        bus(1, `A_TH2, 8'h12);
        fall();
        rdc(`A_RCAPL, 8'h34);
        rdc(`A_RCAPH, 8'h12);
        bus(1, `A_TIMER2_CONTROL, 8'h08);
        bus(1, `A_RCAPL, 8'h78);
        bus(1, `A_RCAPH, 8'h56);
        fall();
        rdc(`A_TL2, 8'h78);
        rdc(`A_TH2, 8'h56);
        end_sim();
    end
endmodule : tb_top
bind core_special_register_bank sfr_bank_monitor sfr_bank_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .stack_push_i(stack_push_i), .pointer_inc_i(pointer_inc_i),
    .pointer_load_i(pointer_load_i), .timer_inc_i(timer_inc_i), .program_status_o(program_status_o),
    .bank_base_o(bank_base_o), .stack_pointer_o(stack_pointer_o), .main_operand_o(main_operand_o),
    .indirect_address_pointer_o(indirect_address_pointer_o), .tx_start_o(tx_start_o),
    .timer_count_o(timer_count_o));
`default_nettype wire
